// ### inc/sldd_params.svh
// Function
// R01 - ten-stage shift register, shifts on rising edge
// R02 - falling shift clock edge changes nothing
// R03 - last stage drives serial chain output
// R04 - ten channel outputs, one latch bit each
// R05 - latch transparent while strobe high
// R06 - latch holds while strobe low
// R07 - force-low input blanks all outputs
// R08 - controller keeps shift clock at most 5MHz
// R09 - controller holds shift clock high 100ns
// R10 - controller holds strobe high 100ns
// R11 - controller waits 50ns before raising strobe
`ifndef SLDD_PARAMS_SVH
`define SLDD_PARAMS_SVH
`define SLDD_WIDTH 10
`define SLDD_FIFO_DEPTH 16
`define SLDD_CLK_PERIOD_NS 5
`define SLDD_CLK_HIGH_MIN_NS 100
`define SLDD_STROBE_HIGH_MIN_NS 100
`define SLDD_CLK_TO_STROBE_MIN_NS 50
`define SLDD_CLK_HIGH_MIN_CYC ((`SLDD_CLK_HIGH_MIN_NS + `SLDD_CLK_PERIOD_NS - 1) / `SLDD_CLK_PERIOD_NS)
`define SLDD_RST_WORD 10'h000
`endif

// ### inc/sldd_pkg.sv
package sldd_pkg;
	typedef logic [9:0] sldd_word_t;
	typedef struct packed {
		logic serial_data;
		logic shift_clk;
		logic latch_strobe;
		logic force_low;
	} sldd_pins_t;
endpackage : sldd_pkg

// ### rtl/sldd_fifo.sv
`timescale 1ns/100ps
module sldd_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	// full at DEPTH entries; count is one bit wider than the pointers so full and empty differ
	assign in_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (count != '0);
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_wr) wr_ptr <= wr_ptr + AW'(1);
			if (do_rd) rd_ptr <= rd_ptr + AW'(1);
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : sldd_fifo

// ### rtl/sldd_driver.sv
`timescale 1ns/100ps
`include "sldd_params.svh"
module sldd_driver
	import sldd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire sldd_pins_t pins,
	output logic serial_out,
	output sldd_word_t channel_out,
	output logic channel_output_first,
	output logic channel_output_last,
	output sldd_word_t word_data,
	output logic word_valid,
	input wire logic word_ready,
	output logic word_overflow
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	sldd_pins_t meta;
	sldd_pins_t sync;
	sldd_pins_t prev;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			meta <= '0;
			sync <= '0;
			prev <= '0;
		end else begin
			meta <= pins;
			sync <= meta;
			prev <= sync;
		end
	end
	logic clk_rise;
	assign clk_rise = sync.shift_clk & ~prev.shift_clk;
	logic strobe_fall;
	assign strobe_fall = prev.latch_strobe & ~sync.latch_strobe;

	// ------------------------------------------------------------
	// shift register
	// ------------------------------------------------------------
	sldd_word_t shift_reg;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			shift_reg <= `SLDD_RST_WORD;
		end else if (clk_rise) begin // [R01]
			shift_reg <= {shift_reg[8:0], sync.serial_data}; // [R01]
		end
		// no update without a rising edge, so falling edges are inert [R02]
	end
	assign serial_out = shift_reg[9]; // [R03]

	// ------------------------------------------------------------
	// latch and blanking
	// ------------------------------------------------------------
	sldd_word_t latch;
	sldd_word_t shown;
	assign shown = sync.latch_strobe ? shift_reg : latch; // [R05] [R06]
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			latch <= `SLDD_RST_WORD;
		end else if (sync.latch_strobe) begin
			latch <= shift_reg; // [R05]
		end
	end
	// outputs registered; one cycle later than the pin would, a trade for clean outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			channel_out <= '0;
		end else if (sync.force_low) begin
			channel_out <= '0; // [R07]
		end else begin
			channel_out <= shown; // [R04] [R07]
		end
	end
	assign channel_output_first = channel_out[0]; // [R04]
	assign channel_output_last = channel_out[9];

	// ------------------------------------------------------------
	// captured words toward the display side
	// ------------------------------------------------------------
	logic fifo_in_ready;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			word_overflow <= 1'b0;
		end else if (strobe_fall & ~fifo_in_ready) begin
			// a full fifo drops the word; the flag stays set until reset
			word_overflow <= 1'b1;
		end
	end
	sldd_fifo #(.WIDTH(`SLDD_WIDTH), .DEPTH(`SLDD_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.in_data(latch),
		.in_valid(strobe_fall),
		.in_ready(fifo_in_ready),
		.out_data(word_data),
		.out_valid(word_valid),
		.out_ready(word_ready)
	);
endmodule : sldd_driver

// ### test/sldd_driver_props.sv
`timescale 1ns/100ps
module sldd_driver_props
	import sldd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire sldd_pins_t pins,
	input wire logic serial_out,
	input wire sldd_word_t channel_out,
	input wire logic channel_output_first,
	input wire logic channel_output_last,
	input wire logic word_overflow
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// pins pass two sync flops, so a level must stand a few cycles first
	sequence quiet; (!pins.latch_strobe && !pins.force_low)[*6]; endsequence
	blank_zero_a: assert property (pins.force_low[*4] |=> !channel_out) else $error("blank");
	last_pin_a: assert property (channel_output_first == channel_out[0] && channel_output_last == channel_out[9])
		else $error("pins");
	latch_hold_a: assert property (quiet |=> $stable(channel_out)) else $error("hold");
	fall_idle_a: assert property ((!pins.shift_clk)[*5] |=> $stable(serial_out)) else $error("fall");
	shift_cause_a: assert property ($changed(serial_out) |-> $past(pins.shift_clk, 2)) else $error("shift");
	latch_pass_a: assert property ((pins.latch_strobe && !pins.force_low)[*5]
		|-> channel_out[9] == $past(serial_out)) else $error("pass");
	ovf_stick_a: assert property (word_overflow |=> word_overflow) else $error("ovf");
endmodule : sldd_driver_props

// ### test/sldd_ctrl_model.sv
`timescale 1ns/100ps
module sldd_ctrl_model
	import sldd_pkg::*;
(
	input wire logic clk_sys,
	output sldd_pins_t pins = 4'h0
);
	task automatic w(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic send(sldd_word_t d);
		for (int i = 9; i >= 0; i--) begin
			pins.serial_data = d[i];
			w(10);
			pins.shift_clk = 1'b1;
			w(20);
			pins.shift_clk = 1'b0;
			w(10);
		end
		// released data line shows the inverse, not a stale bit
		pins.serial_data = ~d[0];
	endtask
	task automatic blank(logic v);
		pins.force_low = v;
	endtask
	// caller keeps strobe high long enough and clear of the last clock rise
	task automatic strobe(logic v);
		pins.latch_strobe = v;
	endtask
	task automatic pulse;
		pins.latch_strobe = 1'b1;
		w(20);
		pins.latch_strobe = 1'b0;
		w(10);
	endtask
endmodule : sldd_ctrl_model

// ### test/sldd_driver_test.sv
`timescale 1ns/100ps
module sldd_driver_test;
	import sldd_pkg::*;
	logic clk_sys = 1'b0, rst_b = 1'b0, word_ready = 1'b0;
	logic serial_out, channel_output_first, channel_output_last, word_valid, word_overflow;
	sldd_pins_t pins;
	sldd_word_t channel_out, word_data;
	int errors = 0;
	int num_checks = 0;
	sldd_ctrl_model m (
		.clk_sys(clk_sys),
		.pins(pins)
	);
	sldd_driver dut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pins(pins),
		.serial_out(serial_out),
		.channel_out(channel_out),
		.channel_output_first(channel_output_first),
		.channel_output_last(channel_output_last),
		.word_data(word_data),
		.word_valid(word_valid),
		.word_ready(word_ready),
		.word_overflow(word_overflow)
	);
	initial forever #2.5 clk_sys = ~clk_sys;
	initial begin
		// scenarios take about 2200 cycles
		repeat (4000) @(posedge clk_sys);
		errors++;
		end_of_test;
	end
	task chk(string n, sldd_word_t s, e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s %h %h", n, e, s);
		end
	endtask
	task end_of_test;
		if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task t_load;
		m.send(10'h1a5);
		m.pulse;
		chk("q", channel_out, 10'h1a5);
		chk("q_first", {9'h000, channel_output_first}, 10'h001);
		chk("q_last", {9'h000, channel_output_last}, 10'h000);
		chk("w", word_data, 10'h1a5);
		m.send(10'h30f);
		chk("so", {9'h000, serial_out}, 10'h001);
		chk("hold", channel_out, 10'h1a5);
	endtask
	task t_blank;
		m.blank(1'b1);
		m.w(8);
		chk("blank", channel_out, 10'h000);
	endtask
	task t_fifo;
		repeat (16) m.pulse;
		chk("ovf", {9'h000, word_overflow}, 10'h001);
		word_ready = 1'b1;
		m.w(40);
		chk("empty", {9'h000, word_valid}, 10'h000);
	endtask
	task t_pass;
		m.blank(1'b0);
		m.w(8);
		chk("unblank", channel_out, 10'h30f);
		m.strobe(1'b1);
		m.send(10'h2c3);
		chk("pass", channel_out, 10'h2c3);
		m.strobe(1'b0);
		m.w(10);
		m.send(10'h000);
		chk("keep", channel_out, 10'h2c3);
	endtask
	initial begin
		m.w(10);
		rst_b = 1'b1;
		t_load;
		t_blank;
		t_fifo;
		t_pass;
		end_of_test;
	end
endmodule : sldd_driver_test
bind sldd_driver sldd_driver_props p (
	.clk_sys(clk_sys),
	.rst_b(rst_b),
	.pins(pins),
	.serial_out(serial_out),
	.channel_out(channel_out),
	.channel_output_first(channel_output_first),
	.channel_output_last(channel_output_last),
	.word_overflow(word_overflow)
);
